/* include/wdt_pkg.sv */
// Shared constants and types for the windowed watchdog and its core-side partner
package wdt_pkg;

	// ************************************************************
	// Configuration word one layout
	// ************************************************************
	localparam int CFG_WORD_WIDTH = 16;
	localparam int CFG_POSTSCALE_LSB = 0;
	localparam int CFG_POSTSCALE_WIDTH = 4;
	localparam int CFG_PRESCALE_SELECT_BIT = 4;
	localparam int CFG_WINDOW_DISABLE_BIT = 5;

	// ************************************************************
	// Watchdog enable configuration field codes
	// ************************************************************
	localparam logic [1:0] ENABLE_ALWAYS = 2'h3;
	localparam logic [1:0] ENABLE_SOFTWARE = 2'h2;
	localparam logic [1:0] ENABLE_NEVER = 2'h0;

	// ************************************************************
	// Reset control register layout
	// ************************************************************
	localparam int RC_WIDTH = 16;
	localparam int RC_SOFT_ENABLE_BIT = 5;
	localparam int RC_TIMEOUT_BIT = 4;
	localparam int RC_SLEEP_BIT = 3;
	localparam int RC_IDLE_BIT = 2;
	localparam logic [RC_WIDTH-1:0] RC_RESET_VALUE = 16'h0000;

	// ************************************************************
	// Prescaler and postscaler sizes
	// ************************************************************
	localparam int PRESCALE_SHORT_RATIO = 32;
	localparam int PRESCALE_LONG_RATIO = 128;
	localparam int PRESCALE_SHORT_BITS = $clog2(PRESCALE_SHORT_RATIO);
	localparam int PRESCALE_WIDTH = $clog2(PRESCALE_LONG_RATIO);
	localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_SHORT_LAST =
		PRESCALE_WIDTH'(PRESCALE_SHORT_RATIO - 1);
	localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_LONG_LAST =
		PRESCALE_WIDTH'(PRESCALE_LONG_RATIO - 1);
	localparam int POSTSCALE_MAX_RATIO = 32768;
	localparam int POSTSCALE_WIDTH = $clog2(POSTSCALE_MAX_RATIO);
	localparam int ELAPSED_WIDTH = PRESCALE_WIDTH + POSTSCALE_WIDTH + 1;

	// ************************************************************
	// Timing of the low-power oscillator tick
	// ************************************************************
	localparam int SYS_CLK_FREQ_HZ = 250000000;
	localparam int LOW_POWER_RC_FREQ_HZ = 31000;
	localparam int LOW_POWER_RC_TICK_CYCLES = SYS_CLK_FREQ_HZ / LOW_POWER_RC_FREQ_HZ;

	// ************************************************************
	// Execution modes
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_IDLE = 2'b10
	} mode_type;

endpackage : wdt_pkg

/* include/wdt_link_if.sv */
// Link between the processor core end and the watchdog end
`timescale 1ns/1ps
interface wdt_link_if;
	import wdt_pkg::*;

	// Core to watchdog, one-cycle pulses except data bits
	logic clearWatchdogInstr;
	logic powerSaveInstr;
	logic powerSaveIdle;
	logic powerSaveExit;
	logic clockSwitchDone;
	logic softEnableWrite;
	logic softEnableData;
	logic timeoutFlagClear;
	logic sleepStatusClear;

	// Watchdog to core
	logic watchdogResetReq;
	logic wakeReq;
	logic [RC_WIDTH-1:0] resetControlReg;

	modport device (
		input clearWatchdogInstr, powerSaveInstr, powerSaveIdle, powerSaveExit,
		input clockSwitchDone, softEnableWrite, softEnableData,
		input timeoutFlagClear, sleepStatusClear,
		output watchdogResetReq, wakeReq, resetControlReg
	);

	modport host (
		output clearWatchdogInstr, powerSaveInstr, powerSaveIdle, powerSaveExit,
		output clockSwitchDone, softEnableWrite, softEnableData,
		output timeoutFlagClear, sleepStatusClear,
		input watchdogResetReq, wakeReq, resetControlReg
	);

endinterface : wdt_link_if

/* rtl/core_watchdog_port.sv */
// Processor core end that issues clear and power-save events to the watchdog
`timescale 1ns/1ps
module core_watchdog_port
	import wdt_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	wdt_link_if.host link,
	input wire logic clearReq,
	input wire logic sleepReq,
	input wire logic idleReq,
	input wire logic wakeEvent,
	input wire logic switchDone,
	input wire logic softEnableSet,
	input wire logic softEnableValue,
	input wire logic flagClearReq,
	output logic running,
	output logic watchdogReset,
	output logic wokeByWatchdog,
	output logic timeoutSeen,
	output logic softEnableState
);

	// ************************************************************
	// Execution mode tracking
	// ************************************************************
	mode_type mode;
	logic inRun;

	assign inRun = (mode == MODE_RUN);

	// A watchdog reset forces the core back to normal running from any mode
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			mode <= MODE_RUN;
		else if (link.watchdogResetReq)
			mode <= MODE_RUN;
		else
		begin
			case (mode)
				MODE_RUN:
				begin
					if (sleepReq)
						mode <= MODE_SLEEP;
					else if (idleReq)
						mode <= MODE_IDLE;
				end
				MODE_SLEEP, MODE_IDLE:
				begin
					if (link.wakeReq || wakeEvent)
						mode <= MODE_RUN; // R10
				end
				default:
					mode <= MODE_RUN;
			endcase
		end
	end

	// ************************************************************
	// Instruction pulses toward the watchdog
	// ************************************************************
	// Clears and power-save entry are only issued while running normally
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link.clearWatchdogInstr <= 1'b0;
			link.powerSaveInstr <= 1'b0;
			link.powerSaveIdle <= 1'b0;
			link.powerSaveExit <= 1'b0;
		end
		else
		begin
			link.clearWatchdogInstr <= inRun && clearReq && !link.watchdogResetReq; // R9 R13
			link.powerSaveInstr <= inRun && (sleepReq || idleReq) && !link.watchdogResetReq;
			link.powerSaveIdle <= !sleepReq && idleReq;
			// Exit is only signalled for a wake the watchdog did not cause itself
			link.powerSaveExit <= !inRun && wakeEvent && !link.wakeReq
				&& !link.watchdogResetReq;
		end
	end

	// Housekeeping pulses: clock switch, soft enable and status clears
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link.clockSwitchDone <= 1'b0;
			link.softEnableWrite <= 1'b0;
			link.softEnableData <= 1'b0;
			link.timeoutFlagClear <= 1'b0;
			link.sleepStatusClear <= 1'b0;
		end
		else
		begin
			link.clockSwitchDone <= switchDone;
			link.softEnableWrite <= softEnableSet;
			link.softEnableData <= softEnableValue;
			link.timeoutFlagClear <= flagClearReq; // R11
			// Hardware leaves the sleep or idle status set, so clear it on any wake
			link.sleepStatusClear <= !inRun && (link.wakeReq || wakeEvent); // R12
		end
	end

	// ************************************************************
	// User-side status
	// ************************************************************
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			running <= 1'b1;
			watchdogReset <= 1'b0;
			wokeByWatchdog <= 1'b0;
			timeoutSeen <= 1'b0;
			softEnableState <= 1'b0;
		end
		else
		begin
			running <= inRun;
			watchdogReset <= link.watchdogResetReq;
			wokeByWatchdog <= link.wakeReq;
			timeoutSeen <= link.resetControlReg[RC_TIMEOUT_BIT];
			softEnableState <= link.resetControlReg[RC_SOFT_ENABLE_BIT];
		end
	end

endmodule : core_watchdog_port

/* rtl/windowed_watchdog_timer.sv */
// Windowed watchdog timer end with prescaler, postscaler and reset-control bits
// Overview of operation
// R1 - Enabling the watchdog starts its oscillator
// R2 - Prescaler divides by 32 or 128
// R3 - Prescaler alone gives about 1 or 4 ms
// R4 - Four-bit postscaler selects sixteen ratios
// R5 - Device reset clears all counters
// R6 - Completed clock switch clears all counters
// R7 - Power-save entry clears all counters
// R8 - Leaving sleep or idle clears counters
// R9 - Clear instruction restarts counting while running
// R10 - Counts in sleep; time-out wakes device
// R11 - Sticky time-out flag, cleared by software
// R12 - Software clears sleep or idle status
// R13 - Windowed clear works only in last quarter
// R14 - Early windowed clear resets the device
// R15 - Window mode when window-disable bit zero
// R16 - Field 11 keeps watchdog always running
// R17 - Field 10 defers to software enable
// R18 - Field 00 keeps watchdog disabled
// R19 - Software enable bit cleared on reset
// R20 - Postscaler setting n divides by 2^n
// R21 - Running time-out resets device, sets flag
`timescale 1ns/1ps
module windowed_watchdog_timer
	import wdt_pkg::*;
#(
	parameter int TICK_CYCLES = LOW_POWER_RC_TICK_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	wdt_link_if.device link,
	input wire logic [CFG_WORD_WIDTH-1:0] configWordOne,
	input wire logic [1:0] watchdogEnableCfg,
	output logic lowPowerRcOscEnable,
	output logic timeoutPulse
);

	localparam int DIV_WIDTH = $clog2(TICK_CYCLES + 1);
	localparam logic [DIV_WIDTH-1:0] DIV_LAST = DIV_WIDTH'(TICK_CYCLES - 1);

	// ************************************************************
	// State
	// ************************************************************
	mode_type mode;
	logic softEnable;
	logic timeoutFlag;
	logic sleepStatus;
	logic idleStatus;
	logic [DIV_WIDTH-1:0] divCount;
	logic oscTick;
	logic [PRESCALE_WIDTH-1:0] preCount;
	logic [POSTSCALE_WIDTH-1:0] postCount;

	// ************************************************************
	// Configuration decode
	// ************************************************************
	logic enabled;
	logic longPrescale;
	logic windowMode;
	logic [CFG_POSTSCALE_WIDTH-1:0] postSelect;
	logic [PRESCALE_WIDTH-1:0] preLast;
	logic [POSTSCALE_WIDTH-1:0] postLast;
	logic [ELAPSED_WIDTH-1:0] elapsed;
	logic [ELAPSED_WIDTH-1:0] period;
	logic [ELAPSED_WIDTH-1:0] windowStart;
	logic windowOpen;
	int preBits;

	// Field 01 is treated like 00: only 11 and 10 may run the watchdog
	assign enabled = (watchdogEnableCfg == ENABLE_ALWAYS) // R16
		|| ((watchdogEnableCfg == ENABLE_SOFTWARE) && softEnable); // R17 R18
	assign longPrescale = configWordOne[CFG_PRESCALE_SELECT_BIT];
	assign windowMode = !configWordOne[CFG_WINDOW_DISABLE_BIT]; // R15
	assign postSelect = configWordOne[CFG_POSTSCALE_LSB +: CFG_POSTSCALE_WIDTH]; // R4

	// Prescale ratio of 32 or 128 ticks; at 31 kHz that is roughly 1 ms or 4 ms
	assign preLast = longPrescale ? PRESCALE_LONG_LAST : PRESCALE_SHORT_LAST; // R2 R3
	assign preBits = longPrescale ? PRESCALE_WIDTH : PRESCALE_SHORT_BITS;
	// Postscale setting n counts 2^n prescaler periods
	assign postLast = POSTSCALE_WIDTH'((32'h1 << postSelect) - 32'h1); // R20

	// Position in the programmed period, and start of its final quarter
	assign elapsed = (ELAPSED_WIDTH'(postCount) << preBits) | ELAPSED_WIDTH'(preCount);
	assign period = ELAPSED_WIDTH'(1) << (preBits + int'(postSelect));
	assign windowStart = period - (period >> 2);
	assign windowOpen = (elapsed >= windowStart); // R13

	// ************************************************************
	// Events
	// ************************************************************
	logic inRun;
	logic expire;
	logic clearTaken;
	logic earlyClear;
	logic counterClear;

	assign inRun = (mode == MODE_RUN);
	assign expire = enabled && oscTick && (preCount == preLast) && (postCount == postLast);
	// Clears only count during normal running; when disabled they are harmless
	assign clearTaken = link.clearWatchdogInstr && inRun
		&& (!windowMode || windowOpen); // R9 R13
	assign earlyClear = link.clearWatchdogInstr && inRun && enabled
		&& windowMode && !windowOpen; // R14
	// Any of these restarts the oscillator divider, prescaler and postscaler
	assign counterClear = !enabled
		|| link.clockSwitchDone // R6
		|| link.powerSaveInstr // R7
		|| link.powerSaveExit // R8
		|| clearTaken
		|| earlyClear
		|| expire;

	// ************************************************************
	// Low-power oscillator model
	// ************************************************************
	// The tick source runs only while the watchdog is enabled
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			divCount <= '0;
			oscTick <= 1'b0;
			lowPowerRcOscEnable <= 1'b0;
		end
		else
		begin
			lowPowerRcOscEnable <= enabled; // R1
			if (counterClear)
			begin
				divCount <= '0;
				oscTick <= 1'b0;
			end
			else if (divCount == DIV_LAST)
			begin
				divCount <= '0;
				oscTick <= 1'b1;
			end
			else
			begin
				divCount <= divCount + 1'b1;
				oscTick <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Prescaler and postscaler
	// ************************************************************
	// Clears win over a tick in the same cycle, so a restart is never missed
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			preCount <= '0; // R5
			postCount <= '0;
		end
		else if (counterClear)
		begin
			preCount <= '0;
			postCount <= '0;
		end
		else if (oscTick) // R10
		begin
			if (preCount == preLast)
			begin
				preCount <= '0;
				postCount <= postCount + 1'b1;
			end
			else
				preCount <= preCount + 1'b1;
		end
	end

	// ************************************************************
	// Execution mode
	// ************************************************************
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			mode <= MODE_RUN;
		else
		begin
			case (mode)
				MODE_RUN:
				begin
					if (link.powerSaveInstr)
						mode <= link.powerSaveIdle ? MODE_IDLE : MODE_SLEEP;
				end
				MODE_SLEEP, MODE_IDLE:
				begin
					if (expire || link.powerSaveExit)
						mode <= MODE_RUN; // R10
				end
				default:
					mode <= MODE_RUN;
			endcase
		end
	end

	// ************************************************************
	// Requests toward the core
	// ************************************************************
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link.watchdogResetReq <= 1'b0;
			link.wakeReq <= 1'b0;
			timeoutPulse <= 1'b0;
		end
		else
		begin
			link.watchdogResetReq <= (expire && inRun) || earlyClear; // R21 R14
			link.wakeReq <= expire && !inRun; // R10
			timeoutPulse <= expire || earlyClear;
		end
	end

	// ************************************************************
	// Reset control bits
	// ************************************************************
	// Set wins over a software clear arriving in the same cycle
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			timeoutFlag <= 1'b0;
		else if (expire || earlyClear)
			timeoutFlag <= 1'b1; // R11
		else if (link.timeoutFlagClear)
			timeoutFlag <= 1'b0;
	end

	// Status stays set after a wake until the core clears it
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sleepStatus <= 1'b0;
			idleStatus <= 1'b0;
		end
		else
		begin
			if (link.powerSaveInstr && inRun && !link.powerSaveIdle)
				sleepStatus <= 1'b1;
			else if (link.sleepStatusClear)
				sleepStatus <= 1'b0; // R12
			if (link.powerSaveInstr && inRun && link.powerSaveIdle)
				idleStatus <= 1'b1;
			else if (link.sleepStatusClear)
				idleStatus <= 1'b0; // R12
		end
	end

	// A watchdog-requested reset is a device reset, so it also drops the enable
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			softEnable <= 1'b0; // R19
		else if ((expire && inRun) || earlyClear)
			softEnable <= 1'b0; // R19
		else if (link.softEnableWrite)
			softEnable <= link.softEnableData;
	end

	// Register view assembled from flops only; unused bits read as zero
	always_comb
	begin
		link.resetControlReg = RC_RESET_VALUE;
		link.resetControlReg[RC_SOFT_ENABLE_BIT] = softEnable;
		link.resetControlReg[RC_TIMEOUT_BIT] = timeoutFlag;
		link.resetControlReg[RC_SLEEP_BIT] = sleepStatus;
		link.resetControlReg[RC_IDLE_BIT] = idleStatus;
	end

endmodule : windowed_watchdog_timer

/* test/windowed_watchdog_timer_props.sv */
// Concurrent checks on the link between the core end and the watchdog end
`timescale 1ns/1ps
module windowed_watchdog_timer_props
	import wdt_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic powerSaveInstr,
	input wire logic powerSaveIdle,
	input wire logic softEnableWrite,
	input wire logic softEnableData,
	input wire logic timeoutFlagClear,
	input wire logic sleepStatusClear,
	input wire logic watchdogResetReq,
	input wire logic wakeReq,
	input wire logic [RC_WIDTH-1:0] resetControlReg
);
	// ************************************************************
	// Link protocol checks
	// ************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// Power-save entry, split by the idle qualifier
	sequence sleepEntry;
		powerSaveInstr && !powerSaveIdle;
	endsequence
	sequence idleEntry;
		powerSaveInstr && powerSaveIdle;
	endsequence
	// A write not overlapped by a reset request in either cycle
	sequence softWrite;
		softEnableWrite && !watchdogResetReq ##1 !watchdogResetReq;
	endsequence

	reset_pulse_single_a: assert property (watchdogResetReq |=> !watchdogResetReq)
		else $error("reset request held for more than one cycle");
	wake_pulse_single_a: assert property (wakeReq |=> !wakeReq)
		else $error("wake request held for more than one cycle");
	reset_sets_flag_a: assert property (watchdogResetReq |-> resetControlReg[RC_TIMEOUT_BIT])
		else $error("reset request without time-out flag");
	flag_stays_set_a: assert property (resetControlReg[RC_TIMEOUT_BIT] && !timeoutFlagClear
		|=> resetControlReg[RC_TIMEOUT_BIT]) else $error("time-out flag dropped by itself");
	wake_from_saving_a: assert property (wakeReq
		|-> resetControlReg[RC_SLEEP_BIT] || resetControlReg[RC_IDLE_BIT])
		else $error("wake request outside sleep or idle");
	sleep_entry_marks_a: assert property (sleepEntry |=> resetControlReg[RC_SLEEP_BIT])
		else $error("sleep entry not marked");
	idle_entry_marks_a: assert property (idleEntry |=> resetControlReg[RC_IDLE_BIT])
		else $error("idle entry not marked");
	status_held_a: assert property (resetControlReg[RC_SLEEP_BIT] && !sleepStatusClear
		|=> resetControlReg[RC_SLEEP_BIT]) else $error("sleep status dropped by itself");
	soft_write_taken_a: assert property (softWrite
		|-> resetControlReg[RC_SOFT_ENABLE_BIT] == $past(softEnableData))
		else $error("soft enable write not taken");
	reset_clears_enable_a: assert property (watchdogResetReq && !softEnableWrite
		|=> !resetControlReg[RC_SOFT_ENABLE_BIT]) else $error("soft enable kept over reset");

endmodule : windowed_watchdog_timer_props

/* test/windowed_watchdog_timer_test.sv */
// Self-checking bench joining the core end and the watchdog end
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
	import wdt_pkg::*;

	// ************************************************************
	// Stimulus, ends and checker
	// ************************************************************
	localparam int T = 4;
	localparam logic [6:0] CLR = 7'h01;
	localparam logic [6:0] SLP = 7'h02;
	localparam logic [6:0] IDL = 7'h04;
	localparam logic [6:0] WAK = 7'h08;
	localparam logic [6:0] SWI = 7'h10;
	localparam logic [6:0] SEN = 7'h20;
	localparam logic [6:0] FCL = 7'h40;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [6:0] req = 7'h00;
	logic softEnableValue = 1'b0;
	logic [15:0] configWordOne = 16'h0000;
	logic [1:0] watchdogEnableCfg = 2'h0;
	logic running, watchdogReset, wokeByWatchdog, timeoutSeen, softEnableState;
	logic lowPowerRcOscEnable, timeoutPulse;
	int n_mismatch = 0;
	int comparisons = 0;
	int base = 0;

	wdt_link_if link();
	core_watchdog_port i_core_watchdog_port (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
		.clearReq(req[0]), .sleepReq(req[1]), .idleReq(req[2]), .wakeEvent(req[3]),
		.switchDone(req[4]), .softEnableSet(req[5]), .softEnableValue(softEnableValue),
		.flagClearReq(req[6]), .running(running), .watchdogReset(watchdogReset),
		.wokeByWatchdog(wokeByWatchdog), .timeoutSeen(timeoutSeen),
		.softEnableState(softEnableState));
	windowed_watchdog_timer #(.TICK_CYCLES(T)) i_windowed_watchdog_timer (.sys_clk(sys_clk),
		.rst_b(rst_b), .link(link), .configWordOne(configWordOne),
		.watchdogEnableCfg(watchdogEnableCfg), .lowPowerRcOscEnable(lowPowerRcOscEnable),
		.timeoutPulse(timeoutPulse));
	windowed_watchdog_timer_props i_windowed_watchdog_timer_props (.sys_clk(sys_clk),
		.rst_b(rst_b), .powerSaveInstr(link.powerSaveInstr), .powerSaveIdle(link.powerSaveIdle),
		.softEnableWrite(link.softEnableWrite), .softEnableData(link.softEnableData),
		.timeoutFlagClear(link.timeoutFlagClear), .sleepStatusClear(link.sleepStatusClear),
		.watchdogResetReq(link.watchdogResetReq), .wakeReq(link.wakeReq),
		.resetControlReg(link.resetControlReg));

	// Free-running system clock
	always #2 sys_clk = ~sys_clk;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic checkRange(input string what, input int lo, input int hi, input int seen);
		comparisons++;
		if (seen < lo || seen > hi)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, seen);
		end
	endtask : checkRange

	task automatic tally_and_finish;
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// One-cycle request pulse; the low edge keeps back-to-back calls apart
	task automatic pulse(input logic [6:0] which);
		@(posedge sys_clk);
		req <= which;
		@(posedge sys_clk);
		req <= 7'h00;
	endtask : pulse

	task automatic setup(input logic [1:0] en, input logic wd, input logic ps, input logic [3:0] n);
		@(posedge sys_clk);
		watchdogEnableCfg <= en;
		configWordOne <= {10'h000, wd, ps, n};
	endtask : setup

	// Counts cycles until a time-out pulse, giving up at the limit
	task automatic waitPulse(input int limit, output int n);
		n = 0;
		@(posedge sys_clk);
		#1;
		while (timeoutPulse !== 1'b1 && n < limit)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask : waitPulse

	// Period is bounded loosely because the tick phase is not visible
	task automatic expectPeriod(input string what, input int ticks, input logic expReset);
		int n;
		logic sawReset;
		logic sawWake;
		waitPulse((T + 1) * ticks + 9, n);
		checkRange(what, T * ticks - 4, (T + 1) * ticks + 8, n);
		sawReset = 1'b0;
		sawWake = 1'b0;
		repeat (3)
		begin
			@(posedge sys_clk);
			#1;
			sawReset |= watchdogReset;
			sawWake |= wokeByWatchdog;
		end
		check("reset request", expReset, sawReset);
		check("wake by timer", !expReset, sawWake);
		check("timeout flag", 1'b1, timeoutSeen);
	endtask : expectPeriod

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic resetState;
		#1;
		check("control register", RC_RESET_VALUE, link.resetControlReg);
		check("running", 1'b1, running);
		check("osc enable", 1'b0, lowPowerRcOscEnable);
	endtask : resetState

	task automatic disabledQuiet;
		int n;
		logic [1:0] codes [2] = '{ENABLE_NEVER, 2'h1};
		@(posedge sys_clk);
		softEnableValue <= 1'b1;
		foreach (codes[i])
		begin
			setup(codes[i], 1'b1, 1'b0, 4'h0);
			pulse(SEN);
			waitPulse(400, n);
			check("disabled quiet", 16'd400, n);
			check("osc off", 1'b0, lowPowerRcOscEnable);
			check("soft bit", 1'b1, softEnableState);
		end
	endtask : disabledQuiet

	task automatic softControl;
		int n;
		setup(ENABLE_SOFTWARE, 1'b1, 1'b0, 4'h0);
		pulse(CLR);
		#1;
		check("osc on", 1'b1, lowPowerRcOscEnable);
		expectPeriod("soft period", PRESCALE_SHORT_RATIO, 1'b1);
		check("soft bit after reset", 1'b0, softEnableState);
		waitPulse(400, n);
		check("soft off quiet", 16'd400, n);
	endtask : softControl

	task automatic periodSweep;
		logic [4:0] table_ [4] = '{5'h00, 5'h10, 5'h01, 5'h02};
		foreach (table_[i])
		begin
			setup(ENABLE_ALWAYS, 1'b1, table_[i][4], table_[i][3:0]);
			pulse(CLR);
			expectPeriod("period", (table_[i][4] ? PRESCALE_LONG_RATIO : PRESCALE_SHORT_RATIO)
				<< table_[i][3:0], 1'b1);
		end
	endtask : periodSweep

	task automatic stickyFlag;
		setup(ENABLE_ALWAYS, 1'b1, 1'b0, 4'h0);
		pulse(CLR);
		repeat (90) @(posedge sys_clk);
		#1;
		check("flag sticky", 1'b1, timeoutSeen);
		pulse(FCL);
		repeat (3) @(posedge sys_clk);
		#1;
		check("flag cleared", 1'b0, timeoutSeen);
	endtask : stickyFlag

	task automatic restartBy;
		int n;
		logic [6:0] kinds [2] = '{CLR, SWI};
		foreach (kinds[i])
			repeat (4)
			begin
				pulse(kinds[i]);
				waitPulse(base * 3 / 4, n);
				check("restart", base * 3 / 4, n);
			end
	endtask : restartBy

	task automatic windowed;
		int n;
		setup(ENABLE_ALWAYS, 1'b0, 1'b0, 4'h0);
		pulse(SWI);
		waitPulse(base * 7 / 8, n);
		check("window start", base * 7 / 8, n);
		pulse(CLR);
		waitPulse(base * 7 / 8, n);
		check("late clear", base * 7 / 8, n);
		// Restart first so the next clear lands well before the window opens
		pulse(SWI);
		pulse(CLR);
		waitPulse(6, n);
		checkRange("early clear", 0, 5, n);
		@(posedge sys_clk);
		#1;
		check("early clear reset", 1'b1, watchdogReset);
	endtask : windowed

	task automatic sleepWake;
		setup(ENABLE_ALWAYS, 1'b1, 1'b0, 4'h0);
		pulse(FCL);
		for (int i = 0; i < 2; i++)
		begin
			pulse(i ? IDL : SLP);
			// Status bit lands one edge after the link pulse
			@(posedge sys_clk);
			#1;
			check("status bit", 1'b1, link.resetControlReg[RC_SLEEP_BIT - i]);
			if (i == 1)
			begin
				repeat (base / 2) @(posedge sys_clk);
				pulse(WAK);
			end
			expectPeriod("saving period", PRESCALE_SHORT_RATIO, i[0]);
			check("running again", 1'b1, running);
			check("status cleared", 1'b0, link.resetControlReg[RC_SLEEP_BIT - i]);
		end
	endtask : sleepWake

	task automatic midReset;
		@(posedge sys_clk);
		softEnableValue <= 1'b1;
		pulse(SEN);
		pulse(SLP);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		check("register in reset", RC_RESET_VALUE, link.resetControlReg);
		check("running in reset", 1'b1, running);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		expectPeriod("after reset", PRESCALE_SHORT_RATIO, 1'b1);
	endtask : midReset

	// ************************************************************
	// Main sequence and hang guard
	// ************************************************************
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		resetState();
		disabledQuiet();
		softControl();
		setup(ENABLE_ALWAYS, 1'b1, 1'b0, 4'h0);
		pulse(CLR);
		waitPulse(400, base);
		periodSweep();
		stickyFlag();
		restartBy();
		windowed();
		sleepWake();
		midReset();
		tally_and_finish();
	end

	// Whole run needs well under 20000 cycles
	initial
	begin
		#80000;
		n_mismatch++;
		tally_and_finish();
	end

endmodule : windowed_watchdog_timer_test
